// file: rtl/hop_shaper_regs.vh
// Register map, field layout, reset values and timing for the spatial hop shaper
// Functional notes
// - One shaper per downstream link and class
// - Arrays of class A, B shapers per segment
// - CreditA0 charged, refilled, capped, passes at MTU
// - CreditA1 charged, refilled, capped, passes at MTU
// - CreditB charged, refilled, capped, passes at MTU
// - CHECK with pass set advances hop, goes LOOP
// - CHECK with pass clear loads result, restarts
// - LOOP below station limit returns to CHECK
// - LOOP at station limit loads result, restarts
// - sendA is max of A0 and min(A1, D)
// - sendB is min of iterated B and D
// - Store-forward queue accepts with one MTU free
// - Cut-through queue accepts only when transmit immediate
// - Class C shapers stay uniform, not built here
// - CreditD charged by A1 and B traffic, not by A0, capped MTU
// - sendD iterated like the other hop results
`ifndef HOP_SHAPER_REGS_VH
`define HOP_SHAPER_REGS_VH

// Word offsets on the Avalon bus, byte address = 4 * index
`define REG_CTRL 4'h0
`define REG_MTU 4'h1
`define REG_JITTER 4'h2
`define REG_BLIMIT 4'h3
`define REG_LINK_SEL 4'h4
`define REG_RATE_A0 4'h5
`define REG_RATE_A1 4'h6
`define REG_RATE_B 4'h7
`define REG_RATE_D 4'h8
`define REG_STATUS 4'h9
`define REG_SEND 4'hA
`define REG_QFREE 4'hB

// Control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_CUT_THROUGH_BIT 1

// Reset values
`define CTRL_RESET 32'h00000001
`define MTU_RESET 32'h000005EE
`define JITTER_RESET 32'h00000100
`define BLIMIT_RESET 32'h00010000

// Timing: one refill tick every 16 cycles, rates are bytes per tick, so bytes per cycle scaled by 1/16
`define RATE_FRAC_BITS 4

`endif

// file: rtl/hop_iterator.v
// Hop-scanning iterator turning per-link pass bits into a hop count
`timescale 1ns/1ps
`default_nettype none
module hop_iterator #(
    parameter STATIONS = 8,
    parameter HW = 4
) (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // Per-link pass bits
    input wire [STATIONS-1:0] pass_bits,
    // Resulting hop count
    output reg [HW-1:0] hops
);
    localparam CHECK = 1'b0;
    localparam LOOP = 1'b1;
    localparam [HW-1:0] MAX_HOP = STATIONS;

    reg state_reg;
    reg [HW-1:0] n_reg;

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_reg <= CHECK;
            n_reg <= {HW{1'b0}};
            hops <= {HW{1'b0}};
        end
        else
        begin
            case (state_reg)
                CHECK:
                begin
                    if (pass_bits[n_reg[HW-2:0]])
                    begin
                        n_reg <= n_reg + 1'b1;
                        state_reg <= LOOP;
                    end
                    else
                    begin
                        hops <= n_reg;
                        n_reg <= {HW{1'b0}};
                    end
                end
                LOOP:
                begin
                    state_reg <= CHECK;
                    if (n_reg >= MAX_HOP)
                    begin
                        hops <= n_reg;
                        n_reg <= {HW{1'b0}};
                    end
                    // Below the limit only the state changes
                end
                default:
                begin
                    state_reg <= CHECK;
                    n_reg <= {HW{1'b0}};
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: rtl/spatial_hop_shaper.v
// Spatial per-link token-bucket shapers with hop-count send indications
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hop_shaper_regs.vh"
module spatial_hop_shaper #(
    parameter STATIONS = 8,
    parameter HW = 4,
    parameter CW = 24
) (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // Avalon-MM slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Client traffic charge, bytes sent this cycle with per-link path mask
    input wire [15:0] client_len,
    input wire client_a0_valid,
    input wire client_a1_valid,
    input wire client_b_valid,
    input wire [STATIONS-1:0] client_path,
    // Stage queue
    input wire [15:0] stage_free,
    input wire stage_tx_ready,
    // Indications to client
    output reg [HW-1:0] send_a,
    output reg [HW-1:0] send_b
);
    localparam NUM_CLS = 4;

    reg [31:0] ctrl_reg;
    reg [31:0] mtu_reg;
    reg [31:0] jitter_reg;
    reg [31:0] blimit_reg;
    reg [31:0] link_sel_reg;
    reg [15:0] rate_a0_reg [0:STATIONS-1];
    reg [15:0] rate_a1_reg [0:STATIONS-1];
    reg [15:0] rate_b_reg [0:STATIONS-1];
    reg [15:0] rate_d_reg [0:STATIONS-1];
    reg ack_pending_reg;

    wire [STATIONS-1:0] pass_a0;
    wire [STATIONS-1:0] pass_a1;
    wire [STATIONS-1:0] pass_b;
    wire [STATIONS-1:0] pass_d;
    wire [HW-1:0] hops_a0;
    wire [HW-1:0] hops_a1;
    wire [HW-1:0] hops_b;
    wire [HW-1:0] hops_d;
    wire [CW-1:0] mtu_c = mtu_reg[CW-1:0];
    wire [2:0] sel = link_sel_reg[2:0];
    wire [3:0] widx = avs_address[5:2];
    wire bus_req = (avs_read | avs_write) & ~ack_pending_reg;
    // Writes land only at the answer edge, while the master still holds them
    wire wr_commit = ack_pending_reg & avs_write;

    // Register access; one wait cycle, answered on the second edge
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            ctrl_reg <= `CTRL_RESET;
            mtu_reg <= `MTU_RESET;
            jitter_reg <= `JITTER_RESET;
            blimit_reg <= `BLIMIT_RESET;
            link_sel_reg <= 32'h00000000;
            ack_pending_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            ack_pending_reg <= bus_req;
            avs_waitrequest <= ~bus_req;
            if (bus_req && avs_read)
            begin
                case (widx)
                    `REG_CTRL: avs_readdata <= ctrl_reg;
                    `REG_MTU: avs_readdata <= mtu_reg;
                    `REG_JITTER: avs_readdata <= jitter_reg;
                    `REG_BLIMIT: avs_readdata <= blimit_reg;
                    `REG_LINK_SEL: avs_readdata <= link_sel_reg;
                    `REG_RATE_A0: avs_readdata <= {16'h0000, rate_a0_reg[sel]};
                    `REG_RATE_A1: avs_readdata <= {16'h0000, rate_a1_reg[sel]};
                    `REG_RATE_B: avs_readdata <= {16'h0000, rate_b_reg[sel]};
                    `REG_RATE_D: avs_readdata <= {16'h0000, rate_d_reg[sel]};
                    `REG_STATUS: avs_readdata <= {pass_d, pass_b, pass_a1, pass_a0};
                    `REG_SEND: avs_readdata <= {16'h0000, hops_d, hops_b, send_b, send_a};
                    `REG_QFREE: avs_readdata <= {16'h0000, stage_free};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
            if (wr_commit)
            begin
                case (widx)
                    `REG_CTRL: ctrl_reg <= {30'h00000000, avs_writedata[1:0]};
                    `REG_MTU: mtu_reg <= avs_writedata;
                    `REG_JITTER: jitter_reg <= avs_writedata;
                    `REG_BLIMIT: blimit_reg <= avs_writedata;
                    `REG_LINK_SEL: link_sel_reg <= {29'h00000000, avs_writedata[2:0]};
                    default: ;
                endcase
            end
        end
    end

    wire enable = ctrl_reg[`CTRL_ENABLE_BIT];
    wire cut_through = ctrl_reg[`CTRL_CUT_THROUGH_BIT];

    // One shaper per link and class
    genvar g;
    generate
        for (g = 0; g < STATIONS; g = g + 1)
        begin : link
            reg [CW-1:0] cred_a0_reg;
            reg [CW-1:0] cred_a1_reg;
            reg [CW-1:0] cred_b_reg;
            reg [CW-1:0] cred_d_reg;
            wire on_path = client_path[g];
            wire [CW-1:0] len = {{(CW-16){1'b0}}, client_len};
            wire [CW-1:0] inc_a0 = {{(CW-16){1'b0}}, rate_a0_reg[g]};
            wire [CW-1:0] inc_a1 = {{(CW-16){1'b0}}, rate_a1_reg[g]};
            wire [CW-1:0] inc_b = {{(CW-16){1'b0}}, rate_b_reg[g]};
            wire [CW-1:0] inc_d = {{(CW-16){1'b0}}, rate_d_reg[g]};
            // Jitter allowance: rate * MAX_JITTER / 2, rate in 1/16 units
            wire [47:0] jit_a0 = rate_a0_reg[g] * jitter_reg[31:0];
            wire [47:0] jit_a1 = rate_a1_reg[g] * jitter_reg[31:0];
            wire [CW-1:0] hi_a0 = mtu_c + jit_a0[CW+`RATE_FRAC_BITS:`RATE_FRAC_BITS+1];
            wire [CW-1:0] hi_a1 = mtu_c + jit_a1[CW+`RATE_FRAC_BITS:`RATE_FRAC_BITS+1];
            wire [CW-1:0] hi_b = blimit_reg[CW-1:0];
            wire [CW-1:0] hi_d = mtu_c;
            // Fractional refill kept crude: one rate unit per 16 cycles
            reg [3:0] tick_reg;
            wire refill = (tick_reg == 4'hF);

            always @(posedge sys_clk)
            begin
                if (srst)
                begin
                    rate_a0_reg[g] <= 16'h0000;
                    rate_a1_reg[g] <= 16'h0000;
                    rate_b_reg[g] <= 16'h0000;
                    rate_d_reg[g] <= 16'h0000;
                end
                else if (wr_commit && sel == g)
                begin
                    if (widx == `REG_RATE_A0)
                        rate_a0_reg[g] <= avs_writedata[15:0];
                    if (widx == `REG_RATE_A1)
                        rate_a1_reg[g] <= avs_writedata[15:0];
                    if (widx == `REG_RATE_B)
                        rate_b_reg[g] <= avs_writedata[15:0];
                    if (widx == `REG_RATE_D)
                        rate_d_reg[g] <= avs_writedata[15:0];
                end
            end

            function [CW-1:0] bucket;
                input [CW-1:0] cur;
                input [CW-1:0] inc;
                input [CW-1:0] dec;
                input [CW-1:0] hi;
                reg [CW:0] up;
                begin
                    up = {1'b0, cur} + {1'b0, inc};
                    if (up > {1'b0, hi})
                        up = {1'b0, hi};
                    // Floor at zero so the counter never wraps
                    if (up[CW-1:0] > dec)
                        bucket = up[CW-1:0] - dec;
                    else
                        bucket = {CW{1'b0}};
                end
            endfunction

            always @(posedge sys_clk)
            begin
                if (srst)
                begin
                    tick_reg <= 4'h0;
                    cred_a0_reg <= {CW{1'b0}};
                    cred_a1_reg <= {CW{1'b0}};
                    cred_b_reg <= {CW{1'b0}};
                    cred_d_reg <= {CW{1'b0}};
                end
                else
                begin
                    tick_reg <= tick_reg + 4'h1;
                    cred_a0_reg <= bucket(cred_a0_reg, refill ? inc_a0 : {CW{1'b0}},
                        (client_a0_valid && on_path) ? len : {CW{1'b0}}, hi_a0);
                    cred_a1_reg <= bucket(cred_a1_reg, refill ? inc_a1 : {CW{1'b0}},
                        (client_a1_valid && on_path) ? len : {CW{1'b0}}, hi_a1);
                    cred_b_reg <= bucket(cred_b_reg, refill ? inc_b : {CW{1'b0}},
                        (client_b_valid && on_path) ? len : {CW{1'b0}}, hi_b);
                    // Spent by non-A0 client traffic; a per-cycle drain against
                    // equal limits would keep the credit below MTU for good
                    cred_d_reg <= bucket(cred_d_reg, refill ? inc_d : {CW{1'b0}},
                        ((client_a1_valid || client_b_valid) && on_path) ? len
                        : {CW{1'b0}}, hi_d);
                end
            end

            assign pass_a0[g] = cred_a0_reg >= mtu_c;
            assign pass_a1[g] = cred_a1_reg >= mtu_c;
            assign pass_b[g] = cred_b_reg >= mtu_c;
            assign pass_d[g] = cred_d_reg >= mtu_c;
        end
    endgenerate

    // Iterators per class
    hop_iterator #(.STATIONS(STATIONS), .HW(HW)) it_a0 (
        .sys_clk(sys_clk), .srst(srst), .pass_bits(pass_a0), .hops(hops_a0));
    hop_iterator #(.STATIONS(STATIONS), .HW(HW)) it_a1 (
        .sys_clk(sys_clk), .srst(srst), .pass_bits(pass_a1), .hops(hops_a1));
    hop_iterator #(.STATIONS(STATIONS), .HW(HW)) it_b (
        .sys_clk(sys_clk), .srst(srst), .pass_bits(pass_b), .hops(hops_b));
    hop_iterator #(.STATIONS(STATIONS), .HW(HW)) it_d (
        .sys_clk(sys_clk), .srst(srst), .pass_bits(pass_d), .hops(hops_d));

    // Stage queue acceptance
    wire sf_accept = {16'h0000, stage_free} >= mtu_reg;
    wire stage_accept = cut_through ? stage_tx_ready : sf_accept;
    wire [HW-1:0] min_a1_d = (hops_a1 < hops_d) ? hops_a1 : hops_d;
    wire [HW-1:0] a_val = (hops_a0 > min_a1_d) ? hops_a0 : min_a1_d;
    wire [HW-1:0] b_val = (hops_b < hops_d) ? hops_b : hops_d;

    // Class C shapers stay uniform and live elsewhere
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            send_a <= {HW{1'b0}};
            send_b <= {HW{1'b0}};
        end
        else
        begin
            send_a <= (enable && stage_accept) ? a_val : {HW{1'b0}};
            send_b <= (enable && stage_accept) ? b_val : {HW{1'b0}};
        end
    end
endmodule
`default_nettype wire

// file: tb/hop_shaper_monitor.sv
// Bus handshake and send indication checker for the spatial hop shaper
`timescale 1ns/1ps
`default_nettype none
`include "hop_shaper_regs.vh"
module hop_shaper_monitor #(
    parameter HW = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register bus
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Stage queue and indications
    input wire logic [15:0] stage_free,
    input wire logic stage_tx_ready,
    input wire logic [HW-1:0] send_a,
    input wire logic [HW-1:0] send_b
);
    logic [31:0] ctrl_reg;
    logic [31:0] mtu_reg;
    wire wr_done = avs_write && !avs_waitrequest;
    // Shadow copies, taken at the write answer edge like the slave does
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            ctrl_reg <= `CTRL_RESET;
            mtu_reg <= `MTU_RESET;
        end
        else if (wr_done && avs_address[5:2] == `REG_CTRL)
            ctrl_reg <= avs_writedata;
        else if (wr_done && avs_address[5:2] == `REG_MTU)
            mtu_reg <= avs_writedata;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered next cycle");
    property p_one_cycle;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("answer longer than one cycle");
    property p_hole;
        avs_read && !avs_waitrequest && avs_address[5:2] > `REG_QFREE |-> avs_readdata == 32'h0;
    endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_ctrl_rd;
        avs_read && !avs_waitrequest && avs_address[5:2] == `REG_CTRL
            |-> avs_readdata[1:0] == ctrl_reg[1:0];
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback differs");
    property p_range;
        send_a <= 4'h8 && send_b <= 4'h8;
    endproperty
    a_range: assert property (p_range) else $error("hop count above station limit");
    property p_sf;
        (!ctrl_reg[`CTRL_CUT_THROUGH_BIT] && {16'h0, stage_free} < mtu_reg) [*3]
            |-> send_a == 0 && send_b == 0;
    endproperty
    a_sf: assert property (p_sf) else $error("send while stage lacks one MTU");
    property p_ct;
        (ctrl_reg[`CTRL_CUT_THROUGH_BIT] && !stage_tx_ready) [*3] |-> send_a == 0 && send_b == 0;
    endproperty
    a_ct: assert property (p_ct) else $error("send while cut-through busy");
    property p_off;
        !ctrl_reg[`CTRL_ENABLE_BIT] [*3] |-> send_a == 0 && send_b == 0;
    endproperty
    a_off: assert property (p_off) else $error("send while disabled");
endmodule
bind spatial_hop_shaper hop_shaper_monitor #(.HW(HW)) u_hop_shaper_monitor (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stage_free(stage_free),
    .stage_tx_ready(stage_tx_ready), .send_a(send_a), .send_b(send_b));
`default_nettype wire

// file: tb/client_voq_model.sv
// Client model holding one pending frame request, charging the shapers
`timescale 1ns/1ps
`default_nettype none
module client_voq_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Indications from the shaper
    input wire logic [3:0] send_a,
    // Frame request from the bench
    input wire logic req,
    input wire logic req_a1,
    input wire logic [3:0] req_hops,
    input wire logic [15:0] req_len,
    // Charge outputs
    output logic [15:0] client_len,
    output logic client_a0_valid,
    output logic client_a1_valid,
    output logic client_b_valid,
    output logic [7:0] client_path
);
    logic pending;
    logic a1_q;
    logic [3:0] hops_q;
    logic [15:0] len_q;
    // Class B never offered: no grant for it exists without downstream credit
    assign client_b_valid = 1'b0;
    always @(posedge sys_clk)
    begin
        client_a0_valid <= 1'b0;
        client_a1_valid <= 1'b0;
        // Unqualified cycles carry junk so stale values cannot be relied on
        client_len <= ~client_len;
        client_path <= ~client_path;
        if (srst)
        begin
            pending <= 1'b0;
            client_len <= 16'h0000;
            client_path <= 8'h00;
        end
        else if (req)
        begin
            pending <= 1'b1;
            a1_q <= req_a1;
            hops_q <= req_hops;
            len_q <= req_len;
        end
        else if (pending && hops_q <= send_a)
        begin
            pending <= 1'b0;
            client_a0_valid <= !a1_q;
            client_a1_valid <= a1_q;
            client_len <= len_q;
            client_path <= 8'hFF >> (4'h8 - hops_q);
        end
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the spatial hop shaper
`timescale 1ns/1ps
`default_nettype none
`include "hop_shaper_regs.vh"
module testbench;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] avs_address = 6'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [15:0] stage_free = 16'hFFFF;
    logic stage_tx_ready = 1'b0;
    logic req = 1'b0;
    logic req_a1 = 1'b0;
    logic [3:0] req_hops = 4'h0;
    logic [15:0] req_len = 16'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, client_a0_valid, client_a1_valid, client_b_valid;
    wire [15:0] client_len;
    wire [7:0] client_path;
    wire [3:0] send_a, send_b;
    integer error_cnt = 0;
    integer total_checks = 0;
    integer cyc = 0;
    always #12.5 sys_clk = ~sys_clk;
    spatial_hop_shaper #(.STATIONS(8), .HW(4), .CW(24)) u_spatial_hop_shaper (
        .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .client_len(client_len),
        .client_a0_valid(client_a0_valid), .client_a1_valid(client_a1_valid),
        .client_b_valid(client_b_valid), .client_path(client_path), .stage_free(stage_free),
        .stage_tx_ready(stage_tx_ready), .send_a(send_a), .send_b(send_b));
    client_voq_model u_client_voq_model (
        .sys_clk(sys_clk), .srst(srst), .send_a(send_a), .req(req), .req_a1(req_a1),
        .req_hops(req_hops), .req_len(req_len), .client_len(client_len),
        .client_a0_valid(client_a0_valid), .client_a1_valid(client_a1_valid),
        .client_b_valid(client_b_valid), .client_path(client_path));
    task wrap_up;
    begin
        if (error_cnt == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task bus(input wr, input [3:0] word, input [31:0] wd, output [31:0] d);
        integer n;
    begin
        @(posedge sys_clk);
        avs_address <= {word, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        n = 0;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 20)
        begin
            @(posedge sys_clk);
            n = n + 1;
        end
        check("bus answer", {31'h0, avs_waitrequest}, 32'h0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    end
    endtask
    task send_frame(input a1, input [3:0] hops);
    begin
        @(posedge sys_clk);
        req <= 1'b1;
        req_a1 <= a1;
        req_hops <= hops;
        req_len <= 16'hFFFF;
        @(posedge sys_clk);
        req <= 1'b0;
        repeat (40) @(posedge sys_clk);
    end
    endtask
    task t_regs;
        logic [31:0] d;
    begin
        check("send_a reset", send_a, 32'h0);
        check("send_b reset", send_b, 32'h0);
        bus(1'b0, `REG_CTRL, 32'h0, d);
        check("ctrl reset", d, `CTRL_RESET);
        bus(1'b0, `REG_MTU, 32'h0, d);
        check("mtu reset", d, `MTU_RESET);
        bus(1'b0, `REG_JITTER, 32'h0, d);
        check("jitter reset", d, `JITTER_RESET);
        bus(1'b0, `REG_BLIMIT, 32'h0, d);
        check("blimit reset", d, `BLIMIT_RESET);
        bus(1'b1, 4'hC, 32'hFFFFFFFF, d);
        bus(1'b0, 4'hC, 32'h0, d);
        check("unmapped read", d, 32'h0);
    end
    endtask
    task t_fill;
        integer i;
        logic [31:0] d;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            bus(1'b1, `REG_LINK_SEL, i, d);
            bus(1'b1, `REG_RATE_A0, 32'h100, d);
            bus(1'b1, `REG_RATE_A1, 32'h100, d);
            bus(1'b1, `REG_RATE_B, 32'h100, d);
            bus(1'b1, `REG_RATE_D, 32'h0, d);
        end
        repeat (3000) @(posedge sys_clk);
        check("send_a all pass", send_a, 32'h8);
        check("send_b no down", send_b, 32'h0);
        bus(1'b0, `REG_STATUS, 32'h0, d);
        check("pass all", d, 32'h00FFFFFF);
    end
    endtask
    task t_charge;
        logic [31:0] d;
    begin
        send_frame(1'b1, 4'h3);
        check("send_a a1 low", send_a, 32'h8);
        bus(1'b0, `REG_STATUS, 32'h0, d);
        check("pass a1", d[15:8], 32'hF8);
        send_frame(1'b0, 4'h1);
        check("send_a a0 low", send_a, 32'h0);
        bus(1'b0, `REG_STATUS, 32'h0, d);
        check("pass a0", d[7:0], 32'hFE);
        repeat (3000) @(posedge sys_clk);
        check("send_a refill", send_a, 32'h8);
    end
    endtask
    task t_down;
        integer i;
        logic [31:0] d;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            bus(1'b1, `REG_LINK_SEL, i, d);
            bus(1'b1, `REG_RATE_D, 32'h100, d);
        end
        repeat (300) @(posedge sys_clk);
        check("send_b down", send_b, 32'h8);
        bus(1'b0, `REG_STATUS, 32'h0, d);
        check("pass d", d[31:24], 32'hFF);
        send_frame(1'b0, 4'h1);
        check("send_a via a1 and d", send_a, 32'h8);
        check("send_b a0 spares d", send_b, 32'h8);
        send_frame(1'b1, 4'h1);
        check("send_b d low", send_b, 32'h0);
    end
    endtask
    task stage_case(input [31:0] ctrl, input [15:0] free, input rdy, input [3:0] exp);
        logic [31:0] d;
    begin
        bus(1'b1, `REG_CTRL, ctrl, d);
        stage_free <= free;
        stage_tx_ready <= rdy;
        repeat (6) @(posedge sys_clk);
        check("send_a stage", send_a, exp);
        check("send_b stage", send_b, 32'h0);
    end
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        t_regs;
        t_fill;
        t_charge;
        stage_case(32'h1, 16'h05ED, 1'b1, 4'h0);
        stage_case(32'h1, 16'h05EE, 1'b0, 4'h8);
        stage_case(32'h3, 16'hFFFF, 1'b0, 4'h0);
        stage_case(32'h3, 16'h0000, 1'b1, 4'h8);
        stage_case(32'h0, 16'hFFFF, 1'b1, 4'h0);
        stage_case(32'h1, 16'hFFFF, 1'b0, 4'h8);
        t_down;
        wrap_up;
    end
    // Run should need about 7000 cycles
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt = error_cnt + 1;
            wrap_up;
        end
    end
endmodule
`default_nettype wire
